// ===== fllsd_defs.vh
// constants of the frequency locked loop speed discriminator
`ifndef FLLSD_DEFS_VH
`define FLLSD_DEFS_VH

// speed select encodings
`define FLLSD_SPD_LOW       2'h0
`define FLLSD_SPD_MID       2'h1
`define FLLSD_SPD_HIGH      2'h2

// discriminator counts in reference clock periods
`define FLLSD_CNT_HIGH      13'h056C
`define FLLSD_CNT_MID       13'h0342
`define FLLSD_CNT_LOW       13'h0682

// index timing in 10 MHz clock cycles, sized for the 16 bit counters
`define FLLSD_IDX_LOW_CYC   16'h4E20        // 20000 cycles, 2.0 ms
`define FLLSD_IDX_HIGH_CYC  16'h411A        // 16666 cycles, low delay / 1.2
`define FLLSD_IDX_MID_CYC   16'h2710        // 10000 cycles, 1.0 ms
`define FLLSD_IDX_PW_CYC    16'h5398        // 21400 cycles, 2.14 ms

`endif

// ===== fllsd_monitor.sv
// port checker for the speed discriminator
`timescale 1ns/100ps
module fllsd_monitor (
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_run_standby_input,
    input wire i_tachometer_pulse_signal,
    input wire o_speed_error_output,
    input wire o_speed_error_oe,
    input wire o_hall_bias_on,
    input wire o_ref_clk,
    input wire o_index_delay_output
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // error drive phases
    sequence s_accel;
        o_speed_error_oe && o_speed_error_output;
    endsequence
    sequence s_decel_start;
        $rose(o_speed_error_oe && !o_speed_error_output);
    endsequence
    AST_REF_DIV: assert property (o_ref_clk |=> !o_ref_clk)
        else $error("reference clock high twice");
    AST_STBY_REF: assert property (i_run_standby_input |=> !o_ref_clk)
        else $error("reference clock runs in standby");
    AST_STBY_OUT: assert property (i_run_standby_input [*2] |-> !o_speed_error_oe)
        else $error("error pin driven in standby");
    AST_HALL_OFF: assert property (i_run_standby_input |=> !o_hall_bias_on)
        else $error("hall bias on in standby");
    AST_HALL_ON: assert property (!i_run_standby_input |=> o_hall_bias_on)
        else $error("hall bias off while running");
    AST_STBY_IDX: assert property (i_run_standby_input |=> !o_index_delay_output)
        else $error("index pulse in standby");
    AST_DECEL_START: assert property (s_decel_start |->
        ($past(i_tachometer_pulse_signal) || $past(i_tachometer_pulse_signal, 2)))
        else $error("deceleration without tach edge");
    AST_ACCEL_HOLD: assert property (s_accel ##0
        !(i_tachometer_pulse_signal || i_run_standby_input) |=> o_speed_error_oe)
        else $error("acceleration dropped early");
endmodule

// ===== fllsd_tach_model.sv
// tachometer pattern source, one rising edge per period
`timescale 1ns/100ps
module fllsd_tach_model (
    input  wire        i_core_clk,
    input  wire        i_en,
    input  wire [15:0] i_period,
    output reg         o_tach
);
    integer cnt = 0;
    // square wave, low and still while disabled
    always @(posedge i_core_clk) begin
        cnt = (!i_en || cnt >= i_period - 1) ? 0 : cnt + 1;
        o_tach <= i_en && (cnt < i_period / 2);
    end
endmodule

// ===== fllsd_top.v
// speed discriminator, standby control and index delay of a spindle servo
`timescale 1ns/100ps
`include "fllsd_defs.vh"

module fllsd_top #(
    parameter [15:0] P_IDX_LOW_CYC  = `FLLSD_IDX_LOW_CYC,
    parameter [15:0] P_IDX_HIGH_CYC = `FLLSD_IDX_HIGH_CYC,
    parameter [15:0] P_IDX_MID_CYC  = `FLLSD_IDX_MID_CYC,
    parameter [15:0] P_IDX_PW_CYC   = `FLLSD_IDX_PW_CYC
) (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_rst_b,
    // control inputs
    input  wire [1:0] i_speed_select_input,
    input  wire       i_run_standby_input,
    // sensor inputs
    input  wire       i_tachometer_pulse_signal,
    input  wire       i_index_sense,
    // speed error, three-state style
    output reg        o_speed_error_output,
    output reg        o_speed_error_oe,
    // hall bias, reference clock and index pulse
    output reg        o_hall_bias_on,
    output reg        o_ref_clk,
    output reg        o_index_delay_output
);

    // discriminator states: waiting for the first edge, then measuring
    localparam S_WAIT = 1'b0;
    localparam S_MEAS = 1'b1;

    // discriminator state and counters
    reg        state;
    reg [12:0] period_cnt;
    reg [12:0] decel_rem;
    // index delay and pulse counters
    reg [15:0] dly_cnt;
    reg [15:0] pw_cnt;
    // speed dependent selections and next values
    reg [12:0] disc_count;
    reg [15:0] idx_delay;
    reg        next_err_out;
    reg        next_err_oe;

    // control decode and compare against twice the count
    wire        standby   = i_run_standby_input;
    wire        ref_tick  = o_ref_clk;                       // one step per two clocks
    wire        tach_edge;                                   // tach rising edge
    wire        idx_cross;                                   // index zero crossing
    wire [12:0] target    = {disc_count[11:0], 1'b0};        // twice the count
    wire        too_slow  = (state == S_MEAS) && (period_cnt >= target);

    // rising edges of the tach pattern
    fllsd_edge #(
        .P_BOTH (0)
    ) fllsd_edge_tach_inst (
        .i_core_clk (i_core_clk),
        .i_level    (i_tachometer_pulse_signal),
        .o_edge     (tach_edge)
    );

    // both edges of the index comparator are zero crossings
    fllsd_edge #(
        .P_BOTH (1)
    ) fllsd_edge_index_inst (
        .i_core_clk (i_core_clk),
        .i_level    (i_index_sense),
        .o_edge     (idx_cross)
    );

    // count and index delay chosen by speed select
    always @* begin
        case (i_speed_select_input)
            `FLLSD_SPD_HIGH: begin
                disc_count = `FLLSD_CNT_HIGH;
                idx_delay  = P_IDX_HIGH_CYC;
            end
            `FLLSD_SPD_MID: begin
                disc_count = `FLLSD_CNT_MID;
                idx_delay  = P_IDX_MID_CYC;
            end
            `FLLSD_SPD_LOW: begin
                disc_count = `FLLSD_CNT_LOW;
                idx_delay  = P_IDX_LOW_CYC;
            end
            // code 3 is treated as high
            default: begin
                disc_count = `FLLSD_CNT_HIGH;
                idx_delay  = P_IDX_HIGH_CYC;
            end
        endcase
    end

    // divide the oscillator by two
    always @(posedge i_core_clk) begin
        if (!i_rst_b || standby) begin
            o_ref_clk <= 1'b0;
        end else begin
            o_ref_clk <= ~o_ref_clk;
        end
    end

    // hall bias follows run/standby
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_hall_bias_on <= 1'b0;
        end else begin
            o_hall_bias_on <= ~standby;
        end
    end

    // tach period measurement and deceleration remainder
    always @(posedge i_core_clk) begin
        if (!i_rst_b || standby) begin
            state      <= S_WAIT;
            period_cnt <= 13'h0000;
            decel_rem  <= 13'h0000;
        end else begin
            case (state)
                S_WAIT: begin
                    if (tach_edge) begin
                        state      <= S_MEAS;
                        period_cnt <= 13'h0000;
                    end
                end
                S_MEAS: begin
                    if (tach_edge) begin
                        period_cnt <= 13'h0000;
                        if (period_cnt < target) begin
                            decel_rem <= target - period_cnt;
                        end else begin
                            decel_rem <= 13'h0000;
                        end
                    end else begin
                        if (ref_tick && !too_slow) begin
                            period_cnt <= period_cnt + 13'h0001;
                        end
                        if (ref_tick && decel_rem != 13'h0000) begin
                            decel_rem <= decel_rem - 13'h0001;
                        end
                    end
                end
                default: begin
                    state <= S_WAIT;
                end
            endcase
        end
    end

    // error drive: high accelerates, low decelerates, released otherwise
    always @* begin
        next_err_out = 1'b0;
        next_err_oe  = 1'b0;
        if (standby) begin
            next_err_oe = 1'b0;
        end else if (too_slow) begin
            next_err_out = 1'b1;
            next_err_oe  = 1'b1;
        end else if (decel_rem != 13'h0000) begin
            next_err_out = 1'b0;
            next_err_oe  = 1'b1;
        end
    end

    // register the error drive and its enable
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_speed_error_output <= 1'b0;
            o_speed_error_oe     <= 1'b0;
        end else begin
            o_speed_error_output <= next_err_out;
            o_speed_error_oe     <= next_err_oe;
        end
    end

    // index delay then output pulse; a new crossing restarts the delay
    always @(posedge i_core_clk) begin
        if (!i_rst_b || standby) begin
            dly_cnt              <= 16'h0000;
            pw_cnt               <= 16'h0000;
            o_index_delay_output <= 1'b0;
        end else begin
            if (idx_cross) begin
                dly_cnt <= idx_delay;
            end else if (dly_cnt != 16'h0000) begin
                dly_cnt <= dly_cnt - 16'h0001;
            end
            // delay expiry loads the pulse width; a crossing wins over expiry
            if (!idx_cross && dly_cnt == 16'h0001) begin
                pw_cnt <= P_IDX_PW_CYC;
            end else if (pw_cnt != 16'h0000) begin
                pw_cnt <= pw_cnt - 16'h0001;
            end
            o_index_delay_output <= (pw_cnt != 16'h0000);
        end
    end

endmodule

// sampled copy of a pin and its edge flag
module fllsd_edge #(
    parameter P_BOTH = 0
) (
    // clock
    input  wire i_core_clk,
    // sampled pin level
    input  wire i_level,
    // edge flag, rising only or both edges
    output wire o_edge
);

    reg level_d;

    // previous sample tracks the pin through reset and standby, so no false edge
    always @(posedge i_core_clk) begin
        level_d <= i_level;
    end

    // rising edge, or any change when both edges count
    assign o_edge = (P_BOTH != 0) ? (i_level ^ level_d) : (i_level & ~level_d);

endmodule

// ===== test_fll_speed_discriminator.sv
// self-checking bench for the speed discriminator
`timescale 1ns/100ps
module test_fll_speed_discriminator;
    reg        clk = 0, rst_b = 0, stby = 1, idx = 0, ten = 0;
    reg  [1:0] sel = 2'h0;
    reg [15:0] per = 16'h0100;
    wire       tach, err, oe, hall, ipulse;
    integer    errors = 0, n_tests = 0, s, k, e, p, t, acc, dec;
    always #50 clk = ~clk;
    fllsd_tach_model fllsd_tach_model_inst (.i_core_clk(clk), .i_en(ten),
        .i_period(per), .o_tach(tach));
    fllsd_top #(.P_IDX_LOW_CYC(16'h0078), .P_IDX_HIGH_CYC(16'h0064),
        .P_IDX_MID_CYC(16'h003C), .P_IDX_PW_CYC(16'h0032)) fllsd_top_inst (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_speed_select_input(sel),
        .i_run_standby_input(stby), .i_tachometer_pulse_signal(tach),
        .i_index_sense(idx), .o_speed_error_output(err), .o_speed_error_oe(oe),
        .o_hall_bias_on(hall), .o_ref_clk(), .o_index_delay_output(ipulse));
    task results;
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input integer got, input integer want, input integer tol);
        n_tests = n_tests + 1;
        if (got > want + tol || got < want - tol) begin
            errors = errors + 1;
            $display("Error %0t: got %0d expected %0d", $time, got, want);
        end
    endtask
    // bounded wait for the index pulse level
    task wait_lvl(input v);
        t = 0;
        while (ipulse !== v && t < 400) begin
            @(negedge clk);
            t = t + 1;
        end
        if (t == 400)
            check(0, 1, 0);
        if (t == 400)
            results;
    endtask
    initial begin
        s = $urandom(32'hf5d0_1f4f);
        repeat (2) @(posedge clk);
        rst_b <= 1;
        stby <= 0;
        // index delay per speed code, code 3 as high, then pulse width
        for (k = 0; k < 4; k = k + 1) begin
            @(posedge clk);
            sel <= k[1:0];
            idx <= ~idx;
            wait_lvl(1);
            check(t, (k == 0 ? 120 : k == 1 ? 60 : 100) + 1, 2);
            wait_lvl(0);
            check(t, 50, 2);
        end
        // slow and fast tach per speed, error cycles against the model
        for (k = 0; k < 6; k = k + 1) begin
            @(posedge clk);
            e = 50 + $urandom % 200;
            t = 2 * (k / 2 == 2 ? 1388 : k / 2 == 1 ? 834 : 1666);
            p = k % 2 ? 2 * t + e : 2 * t - e;
            sel <= k[2:1];
            per <= p[15:0];
            stby <= 1;
            ten <= 0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            check(hall === 1'b0, 1, 0);
            @(posedge clk);
            stby <= 0;
            repeat (4) @(posedge clk);
            ten <= 1;
            acc = 0;
            dec = 0;
            repeat (p * 3 / 2) begin
                @(negedge clk);
                acc = acc + (oe === 1'b1 && err === 1'b1);
                dec = dec + (oe === 1'b1 && err === 1'b0);
            end
            check(acc, k % 2 ? e : 0, 8);
            check(dec, k % 2 ? 0 : e, 8);
            check(hall === 1'b1, 1, 0);
        end
        results;
    end
endmodule
bind fllsd_top fllsd_monitor fllsd_monitor_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_run_standby_input(i_run_standby_input), .o_ref_clk(o_ref_clk),
    .i_tachometer_pulse_signal(i_tachometer_pulse_signal), .o_hall_bias_on(o_hall_bias_on),
    .o_speed_error_output(o_speed_error_output), .o_speed_error_oe(o_speed_error_oe),
    .o_index_delay_output(o_index_delay_output));
